// [bench/host_channel_model.sv]
// host channel model: shared irq and drq lines plus the dma terminal count source
`timescale 1ns/10ps
`default_nettype none

module host_channel_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] irq_i,
	input  wire logic [7:0] irq_oe_i,
	input  wire logic [7:0] drq_i,
	input  wire logic [7:0] drq_oe_i,
	output logic      [7:0] irq_line_o,
	output logic      [7:0] drq_line_o,
	output logic            tc_a_o,
	output logic            tc_b_o
);
	// a line nobody drives rests low on the host terminator, so a stuck enable shows
	assign irq_line_o = irq_i & irq_oe_i;
	assign drq_line_o = drq_i & drq_oe_i;

	// terminal count lines idle low
	initial
	begin
		tc_a_o = 1'h0;
		tc_b_o = 1'h0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// held four cycles so the pin synchroniser surely sees it
	task automatic pulse_tc(input logic on_b);
		if (on_b)
			tc_b_o <= 1'h1;
		else
			tc_a_o <= 1'h1;
		repeat (4) @(posedge clk_i);
		tc_a_o <= 1'h0;
		tc_b_o <= 1'h0;
	endtask
endmodule
`default_nettype wire

// [bench/tb_top.sv]
// self-checking bench for the host bus port and its adc result fifo
`timescale 1ns/10ps
`default_nettype none

module tb_top;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        ce_i = 1'h1;
	logic        cyc_i = 1'h0;
	logic        stb_i = 1'h0;
	logic        we_i = 1'h0;
	logic [9:0]  adr_i = 10'h000;
	logic [1:0]  sel_i = 2'h0;
	logic [15:0] dat_i = 16'h0000;
	logic        conv_done_i = 1'h0;
	logic [15:0] conv_data_i = 16'h0000;
	logic        acq_done_i = 1'h0;
	logic        dac_fifo_req_i = 1'h0;
	logic        dac_done_i = 1'h0;
	logic        dac_upd_int_i = 1'h1;
	logic        dac_upd_ext_i = 1'h1;
	logic        eisa_i = 1'h0;
	logic        tc_a;
	logic        tc_b;
	logic [15:0] dat_o;
	logic        ack_o;
	logic        board_sel_o;
	logic        io16_o;
	logic        ovf_o;
	logic [7:0]  drq_o;
	logic [7:0]  drq_oe_o;
	logic [7:0]  irq_o;
	logic [7:0]  irq_oe_o;
	logic [7:0]  irq_line;
	logic [7:0]  drq_line;
	logic [15:0] rd;
	logic        bsel_seen;
	logic        io16_seen;
	int          fails = 0;
	int          comparisons = 0;
	int unsigned cbit [8] = '{hbp_pkg::C_ADC, hbp_pkg::C_ACQ, hbp_pkg::C_TC, hbp_pkg::C_DACF,
		hbp_pkg::C_DACD, hbp_pkg::C_UPD, hbp_pkg::C_TC, hbp_pkg::C_UPD};

	// 125 MHz clock
	always #4 clk_i = ~clk_i;

	host_bus_port_adc_fifo DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
		.ack_o(ack_o), .board_sel_o(board_sel_o), .io16_o(io16_o), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .acq_done_i(acq_done_i), .dac_fifo_req_i(dac_fifo_req_i),
		.dac_done_i(dac_done_i), .dac_upd_int_i(dac_upd_int_i), .dac_upd_ext_i(dac_upd_ext_i),
		.dma_tc_a_i(tc_a), .dma_tc_b_i(tc_b), .eisa_i(eisa_i), .drq_o(drq_o),
		.drq_oe_o(drq_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .ovf_o(ovf_o));

	host_channel_model HCM (.clk_i(clk_i), .irq_i(irq_o), .irq_oe_i(irq_oe_o), .drq_i(drq_o),
		.drq_oe_i(drq_oe_o), .irq_line_o(irq_line), .drq_line_o(drq_line), .tc_a_o(tc_a),
		.tc_b_o(tc_b));

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// one classic cycle; request held until ack is sampled, then one idle cycle
	task automatic wb(input logic w, input logic [4:0] off, input logic [1:0] s,
		input logic [15:0] d);
		int n;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		adr_i <= hbp_pkg::BASE_DEFAULT + {5'h00, off};
		sel_i <= s;
		dat_i <= d;
		for (n = 0; n < 20; n++)
		begin
			@(posedge clk_i);
			if (ack_o === 1'h1)
				break;
		end
		if (n == 20)
		begin
			fails++;
			$display("CHECK FAILED at %0t: no ack", $time);
			summarize();
		end
		rd = dat_o;
		bsel_seen = board_sel_o;
		io16_seen = io16_o;
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		we_i <= 1'h0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [4:0] off, input logic [15:0] d);
		wb(1'h1, off, hbp_pkg::SEL_WORD, d);
	endtask

	task automatic rdw(input logic [4:0] off, input logic [15:0] exp);
		wb(1'h0, off, hbp_pkg::SEL_WORD, 16'h0000);
		check(rd, exp);
	endtask

	// foreign address: must stay silent for a while
	task automatic noack(input logic [9:0] a);
		logic hit;
		hit = 1'h0;
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		adr_i <= a;
		sel_i <= hbp_pkg::SEL_WORD;
		repeat (6)
		begin
			@(posedge clk_i);
			hit = hit | ack_o | board_sel_o;
		end
		check({15'h0000, hit}, 16'h0000);
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		@(posedge clk_i);
	endtask

	// back-to-back conversions, data base+i
	task automatic push_n(input int n, input logic [15:0] base);
		conv_done_i <= 1'h1;
		for (int i = 0; i < n; i++)
		begin
			conv_data_i <= base + 16'(i);
			@(posedge clk_i);
		end
		conv_done_i <= 1'h0;
		@(posedge clk_i);
	endtask

	// raise one interrupt event; the tc pulses come from the host model
	task automatic fire(input int k);
		case (k)
			1: acq_done_i <= 1'h1;
			2: HCM.pulse_tc(1'h0);
			3: dac_fifo_req_i <= 1'h1;
			4: dac_done_i <= 1'h1;
			5: dac_upd_int_i <= 1'h0;
			6: HCM.pulse_tc(1'h1);
			default: dac_upd_ext_i <= 1'h0;
		endcase
		repeat (4) @(posedge clk_i);
		acq_done_i <= 1'h0;
		dac_fifo_req_i <= 1'h0;
		dac_done_i <= 1'h0;
		dac_upd_int_i <= 1'h1;
		dac_upd_ext_i <= 1'h1;
		repeat (5) @(posedge clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'h0;
		@(posedge clk_i);
		check({irq_oe_o, drq_oe_o}, 16'h0000);
		rdw(hbp_pkg::OFF_STAT, 16'h4000);
		check({14'h0000, bsel_seen, io16_seen}, 16'h0003);
		rdw(hbp_pkg::OFF_IEN, 16'h0000);
		rdw(hbp_pkg::OFF_DMA, 16'h0000);
		rdw(hbp_pkg::OFF_PEND, 16'h0000);
		$display("test reset done");
		noack(10'h240);
		noack(10'h21e);
		noack(10'h020);
		// wrong-size accesses are refused by the port
		wb(1'h1, hbp_pkg::OFF_IEN, hbp_pkg::SEL_BYTE, 16'h003f);
		rdw(hbp_pkg::OFF_IEN, 16'h0000);
		wb(1'h1, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_BYTE, 16'h0005);
		wb(1'h0, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_WORD, 16'h0000);
		check(rd, 16'h0000);
		wb(1'h0, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_BYTE, 16'h0000);
		check(rd, 16'h0005);
		$display("test decode done");
		push_n(3, 16'h8001);
		rdw(hbp_pkg::OFF_STAT, 16'h0003);
		rdw(hbp_pkg::OFF_FIFO, 16'h8001);
		wr(hbp_pkg::OFF_FMT, 16'h0001);
		rdw(hbp_pkg::OFF_FIFO, 16'h0002);
		wr(hbp_pkg::OFF_FMT, 16'h0000);
		rdw(hbp_pkg::OFF_FIFO, 16'h8003);
		rdw(hbp_pkg::OFF_STAT, 16'h4000);
		$display("test fifo done");
		wr(hbp_pkg::OFF_IEN, 16'h0001);
		push_n(1, 16'h1234);
		for (int s = 0; s < 8; s++)
		begin
			wb(1'h1, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_BYTE, 16'(s));
			check({irq_oe_o, irq_line}, {2{8'h01 << s}});
		end
		wb(1'h0, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_BYTE, 16'h0000);
		check({io16_seen, rd[14:0]}, 16'h0007);
		wr(hbp_pkg::OFF_IEN, 16'h0000);
		check({8'h00, irq_oe_o}, 16'h0000);
		wr(hbp_pkg::OFF_DMA, 16'h010a);
		check({drq_o, drq_line}, 16'h2020);
		dac_fifo_req_i <= 1'h1;
		wr(hbp_pkg::OFF_DMA, 16'h037d);
		check({8'h00, drq_line}, 16'h00c0);
		dac_fifo_req_i <= 1'h0;
		wr(hbp_pkg::OFF_DMA, 16'h0102);
		check({8'h00, drq_line}, 16'h0000);
		eisa_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		check({8'h00, drq_line}, 16'h0002);
		rdw(hbp_pkg::OFF_FIFO, 16'h1234);
		check({8'h00, drq_line}, 16'h0000);
		wr(hbp_pkg::OFF_ICLR, 16'h003f);
		$display("test irq routing and dma done");
		wr(hbp_pkg::OFF_IEN, 16'h003f);
		wb(1'h1, hbp_pkg::OFF_IRQSEL, hbp_pkg::SEL_BYTE, 16'h0003);
		for (int k = 1; k < 8; k++)
		begin
			fire(k);
			rdw(hbp_pkg::OFF_PEND, 16'h0001 << cbit[k]);
			check({8'h00, irq_line}, 16'h0008);
			wr(hbp_pkg::OFF_ICLR, 16'h0001 << cbit[k]);
			rdw(hbp_pkg::OFF_PEND, 16'h0000);
			check({irq_oe_o, irq_line}, 16'h0000);
		end
		$display("test causes done");
		push_n(513, 16'h0000);
		check({15'h0000, ovf_o}, 16'h0001);
		rdw(hbp_pkg::OFF_STAT, 16'h8200);
		for (int i = 0; i < 512; i++)
			rdw(hbp_pkg::OFF_FIFO, 16'(i));
		rdw(hbp_pkg::OFF_STAT, 16'hc000);
		rdw(hbp_pkg::OFF_PEND, 16'h0003);
		// overflow clears by its own bit and leaves the causes pending
		wr(hbp_pkg::OFF_ICLR, 16'h0040);
		rdw(hbp_pkg::OFF_STAT, 16'h4000);
		check({15'h0000, ovf_o}, 16'h0000);
		rdw(hbp_pkg::OFF_PEND, 16'h0003);
		wr(hbp_pkg::OFF_ICLR, 16'h003f);
		rdw(hbp_pkg::OFF_PEND, 16'h0000);
		$display("test overflow done");
		// a frozen clock enable must swallow the conversion
		ce_i <= 1'h0;
		push_n(1, 16'h5555);
		ce_i <= 1'h1;
		rdw(hbp_pkg::OFF_STAT, 16'h4000);
		$display("test clock enable done");
		summarize();
	end
endmodule
`default_nettype wire

// [design/host_bus_port_adc_fifo.sv]
// host bus port: decode, 8/16-bit transfers, irq routing, dma requests, adc fifo
//
// What this block does
// - only ten address bits are decoded, base on any 32-byte boundary 000 to 3e0.
// - bits 9..5 select the board, bits 4..0 select the register.
// - default base is 220, registers span 220 to 23f.
// - both 8-bit and 16-bit transfers, size from byte enables.
// - tell the host board selected, ready for next transfer, and width.
// - interrupt lines are three-state so they can be shared.
// - one register-picked line among irq 3,4,5,7,10,11,12,15.
// - six interrupt causes, each with own enable and own clear.
// - causes include adc fifo service and acquisition done or error.
// - a dma terminal count on channel a or b raises a cause.
// - dac fifo service, dac sequence done, dac update falling edge.
// - dma request while adc fifo has data or dac fifo wants data.
// - 16-bit dma on channels 5,6,7; 0..3 only in eisa hosts.
// - register picks single or dual dma mode and the channels.
// - each conversion result is pushed into a 16x512 fifo.
// - a stored result frees the converter for the next conversion.
// - a result arriving with 512 unread values flags overflow and is lost.
// - a non-empty adc fifo can request dma or interrupt service.
// - unipolar straight binary, bipolar two's complement, set by software.
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

module host_bus_port_adc_fifo #(
	parameter logic [9:0] BASE_ADDR = hbp_pkg::BASE_DEFAULT
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        ce_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [9:0]  adr_i,
	input  wire logic [1:0]  sel_i,
	input  wire logic [15:0] dat_i,
	output logic      [15:0] dat_o,
	output logic             ack_o,
	output logic             board_sel_o,
	output logic             io16_o,
	input  wire logic        conv_done_i,
	input  wire logic [15:0] conv_data_i,
	input  wire logic        acq_done_i,
	input  wire logic        dac_fifo_req_i,
	input  wire logic        dac_done_i,
	input  wire logic        dac_upd_int_i,
	input  wire logic        dac_upd_ext_i,
	input  wire logic        dma_tc_a_i,
	input  wire logic        dma_tc_b_i,
	input  wire logic        eisa_i,
	output logic      [7:0]  drq_o,
	output logic      [7:0]  drq_oe_o,
	output logic      [7:0]  irq_o,
	output logic      [7:0]  irq_oe_o,
	output logic             ovf_o
);

	////////////////////////////////////////////////////////////////////////////
	// decode helpers

	// only the irq line select register is byte wide
	function automatic logic is_word_reg(input logic [4:0] off);
		is_word_reg = (off != hbp_pkg::OFF_IRQSEL);
	endfunction

	// host channel 4 is the cascade; 0..3 carry 16-bit dma only in eisa hosts
	function automatic logic chan_ok(input logic [2:0] ch, input logic eisa);
		chan_ok = ch[2] ? (ch != 3'h4) : eisa;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	hbp_pkg::state_type s_ff;
	hbp_pkg::state_type nxt_s;

	logic [4:0]  off;
	logic        hit;
	logic        take;
	logic        done;
	logic        size_ok;
	logic        pop;
	logic        push;
	logic        ovf_ev;
	logic [5:0]  set_ev;
	logic [5:0]  clr_ev;
	logic [15:0] head;
	logic [15:0] rd_mux;
	logic        adc_req;
	logic        dac_req;
	logic        req_a;
	logic        req_b;
	logic [2:0]  ch_a;
	logic [2:0]  ch_b;
	logic        ok_a;
	logic        ok_b;
	logic        dual;
	logic        irq_act;
	logic        ovf_clr;

	// board decode on address bits 9..5, register on 4..0
	assign off         = adr_i[4:0];
	assign hit         = (adr_i[9:hbp_pkg::BRD_LSB] ==
	                      BASE_ADDR[9:hbp_pkg::BRD_LSB]);
	assign board_sel_o = cyc_i & stb_i & hit;
	assign io16_o      = board_sel_o & is_word_reg(off);
	assign ack_o       = (s_ff.ph == hbp_pkg::PH_ACK);
	assign take        = board_sel_o & (s_ff.ph == hbp_pkg::PH_IDLE);
	assign done        = board_sel_o & ack_o;
	// a mismatched size is acked but writes nothing and reads zero
	assign size_ok     = (sel_i == (is_word_reg(off) ? hbp_pkg::SEL_WORD
	                                                  : hbp_pkg::SEL_BYTE));
	assign dat_o       = s_ff.dat;
	assign ovf_o       = s_ff.ovf;

	// fifo head, flipped msb gives two's complement in bipolar mode
	assign head = s_ff.mem[s_ff.rd_ptr] ^
	              (s_ff.bipolar ? hbp_pkg::SIGN_FLIP : 16'h0000);

	// a read that removes data happens at the edge that sees ack
	assign pop    = done & ~we_i & size_ok & (off == hbp_pkg::OFF_FIFO) &
	                (s_ff.count != 10'h000);
	assign ovf_ev = conv_done_i & (s_ff.count == hbp_pkg::FIFO_FULL);
	// a pop in the same cycle does not make room: the full check is on the old count
	assign push   = conv_done_i & ~ovf_ev;
	// overflow has its own clear bit, independent of the six cause bits
	assign ovf_clr = done & we_i & size_ok & (off == hbp_pkg::OFF_ICLR) &
	                 dat_i[hbp_pkg::CLR_OVF];

	////////////////////////////////////////////////////////////////////////////
	// dma request steering

	assign dual    = s_ff.dma_ctl[hbp_pkg::DMA_DUAL];
	assign ch_a    = s_ff.dma_ctl[hbp_pkg::DMA_A_LSB +: 3];
	assign ch_b    = s_ff.dma_ctl[hbp_pkg::DMA_B_LSB +: 3];
	assign ok_a    = chan_ok(ch_a, s_ff.eisa[1]);
	assign ok_b    = chan_ok(ch_b, s_ff.eisa[1]) & dual;
	assign adc_req = s_ff.dma_ctl[hbp_pkg::DMA_ADC_EN] &
	                 (s_ff.count != 10'h000);
	assign dac_req = s_ff.dma_ctl[hbp_pkg::DMA_DAC_EN] & dac_fifo_req_i;
	// single mode shares channel a between both fifos
	assign req_a   = dual ? adc_req : (adc_req | dac_req);
	assign req_b   = dual & dac_req;
	assign irq_act = |(s_ff.pend & s_ff.ien);

	// one three-state driver per host dma and irq line
	for (genvar i = 0; i < 8; i++)
	begin : g_lines
		assign drq_oe_o[i] = (ok_a & (ch_a == 3'(i))) | (ok_b & (ch_b == 3'(i)));
		assign drq_o[i]    = (ok_a & (ch_a == 3'(i)) & req_a) |
		                     (ok_b & (ch_b == 3'(i)) & req_b);
		// line i is irq 3,4,5,7,10,11,12,15 in that order
		assign irq_oe_o[i] = irq_act & (s_ff.irq_sel == 3'(i));
		assign irq_o[i]    = irq_oe_o[i];
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux, captured when the request is taken

	always_comb
	begin
		rd_mux = 16'h0000;
		case (off)
			hbp_pkg::OFF_FIFO:   rd_mux = head;
			hbp_pkg::OFF_STAT:   rd_mux = {s_ff.ovf, (s_ff.count == 10'h000), 4'h0,
			                               s_ff.count};
			hbp_pkg::OFF_IEN:    rd_mux = {10'h000, s_ff.ien};
			hbp_pkg::OFF_DMA:    rd_mux = {6'h00, s_ff.dma_ctl};
			hbp_pkg::OFF_FMT:    rd_mux = {15'h0000, s_ff.bipolar};
			hbp_pkg::OFF_IRQSEL: rd_mux = {13'h0000, s_ff.irq_sel};
			hbp_pkg::OFF_PEND:   rd_mux = {10'h000, s_ff.pend};
			default:             rd_mux = 16'h0000;
		endcase
		if (!size_ok)
			rd_mux = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt cause events

	always_comb
	begin
		set_ev               = 6'h00;
		set_ev[hbp_pkg::C_ADC]  = (s_ff.count != 10'h000);
		set_ev[hbp_pkg::C_ACQ]  = acq_done_i | ovf_ev;
		set_ev[hbp_pkg::C_TC]   = (s_ff.tc_a[1] & ~s_ff.tc_prev[1]) |
		                          (s_ff.tc_b[1] & ~s_ff.tc_prev[0]);
		set_ev[hbp_pkg::C_DACF] = dac_fifo_req_i;
		set_ev[hbp_pkg::C_DACD] = dac_done_i;
		set_ev[hbp_pkg::C_UPD]  = (~s_ff.upd[1] & s_ff.upd_prev) |
		                          (~dac_upd_int_i & s_ff.int_prev);
		clr_ev = 6'h00;
		if (done & we_i & size_ok & (off == hbp_pkg::OFF_ICLR))
			clr_ev = dat_i[5:0];
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		nxt_s = s_ff;
		// pins pass two flops before use
		nxt_s.tc_a     = {s_ff.tc_a[0], dma_tc_a_i};
		nxt_s.tc_b     = {s_ff.tc_b[0], dma_tc_b_i};
		nxt_s.upd      = {s_ff.upd[0], dac_upd_ext_i};
		nxt_s.eisa     = {s_ff.eisa[0], eisa_i};
		nxt_s.tc_prev  = {s_ff.tc_a[1], s_ff.tc_b[1]};
		nxt_s.upd_prev = s_ff.upd[1];
		nxt_s.int_prev = dac_upd_int_i;

		// one wait state, then ack for a single cycle
		case (s_ff.ph)
			hbp_pkg::PH_IDLE: if (take)
			begin
				nxt_s.ph  = hbp_pkg::PH_ACK;
				nxt_s.dat = rd_mux;
			end
			hbp_pkg::PH_ACK:  nxt_s.ph = hbp_pkg::PH_IDLE;
			default:          nxt_s.ph = hbp_pkg::PH_IDLE;
		endcase

		// register writes land at the ack edge
		if (done & we_i & size_ok)
		begin
			case (off)
				hbp_pkg::OFF_IEN:    nxt_s.ien = dat_i[5:0];
				hbp_pkg::OFF_DMA:    nxt_s.dma_ctl = dat_i[9:0];
				hbp_pkg::OFF_FMT:    nxt_s.bipolar = dat_i[hbp_pkg::FMT_BIP];
				hbp_pkg::OFF_IRQSEL: nxt_s.irq_sel = dat_i[2:0];
				default:             nxt_s.irq_sel = s_ff.irq_sel;
			endcase
		end

		// sticky causes: a new event beats a clear in the same cycle
		nxt_s.pend = (s_ff.pend & ~clr_ev) | set_ev;
		nxt_s.ovf  = (s_ff.ovf & ~ovf_clr) | ovf_ev;

		// fifo storage
		if (push)
		begin
			nxt_s.mem[s_ff.wr_ptr] = conv_data_i;
			nxt_s.wr_ptr           = s_ff.wr_ptr + 9'h001;
		end
		if (pop)
			nxt_s.rd_ptr = s_ff.rd_ptr + 9'h001;
		nxt_s.count = s_ff.count + {9'h000, push} - {9'h000, pop};
	end

	////////////////////////////////////////////////////////////////////////////
	// state register, frozen while ce_i is low

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s_ff         <= '0;
			s_ff.ph      <= hbp_pkg::PH_IDLE;
			s_ff.ien     <= hbp_pkg::IEN_RST;
			s_ff.irq_sel <= hbp_pkg::IRQ_RST;
			s_ff.dma_ctl <= hbp_pkg::DMA_RST;
			s_ff.upd     <= 2'h3;                                            // update idles high
			s_ff.upd_prev <= 1'b1;
			s_ff.int_prev <= 1'b1;
		end
		else if (ce_i)
			s_ff <= nxt_s;
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_taken;
		board_sel_o && !ack_o && ce_i;
	endsequence
	sequence s_answer;
		ack_o ##1 (!ack_o || $past(!ce_i));
	endsequence

	property p_ack_seq;
		s_taken |=> s_answer;
	endproperty
	a_ack_seq: assert property (p_ack_seq) else $error("ack not one cycle after request");

	property p_width;
		board_sel_o |-> (io16_o == (adr_i[4:0] != hbp_pkg::OFF_IRQSEL));
	endproperty
	a_width: assert property (p_width) else $error("transfer width wrong");

	property p_decode;
		(cyc_i && stb_i && adr_i[9:5] != BASE_ADDR[9:5]) |-> !board_sel_o && !io16_o;
	endproperty
	a_decode: assert property (p_decode) else $error("board selected off base");

	property p_overflow;
		(ce_i && conv_done_i && s_ff.count == 10'h200)
			|=> ovf_o && s_ff.count == 10'h200 - {9'h000, $past(pop)};
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow not flagged");

	// the clear bit alone must drop the flag when no new overflow arrives
	property p_ovf_clear;
		(ce_i && ovf_clr && !ovf_ev) |=> !ovf_o;
	endproperty
	a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");

	property p_push;
		(ce_i && conv_done_i && s_ff.count < 10'h200 && !pop)
			|=> s_ff.count == $past(s_ff.count) + 10'h001;
	endproperty
	a_push: assert property (p_push) else $error("result not stored");

	property p_pop;
		(ce_i && pop && !conv_done_i) |=> s_ff.count == $past(s_ff.count) - 10'h001;
	endproperty
	a_pop: assert property (p_pop) else $error("read did not remove result");

	property p_irq_route;
		irq_act |-> irq_oe_o == (8'h01 << s_ff.irq_sel) && irq_o == irq_oe_o;
	endproperty
	a_irq_route: assert property (p_irq_route) else $error("irq on wrong line");

	property p_irq_float;
		!irq_act |-> irq_oe_o == 8'h00;
	endproperty
	a_irq_float: assert property (p_irq_float) else $error("irq driven while idle");

	property p_set_wins;
		(ce_i && set_ev[hbp_pkg::C_TC]) |=> s_ff.pend[hbp_pkg::C_TC];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("tc event lost");

	property p_no_low_dma;
		!s_ff.eisa[1] |-> drq_oe_o[3:0] == 4'h0 && drq_oe_o[4] == 1'b0;
	endproperty
	a_no_low_dma: assert property (p_no_low_dma) else $error("bad dma channel driven");

endmodule

`default_nettype wire

// [include/hbp_pkg.sv]
// constants and types shared by the host bus port with its adc result fifo
package hbp_pkg;

	// fifo geometry
	localparam int unsigned FIFO_DEPTH = 512;
	localparam int unsigned PTR_W      = 9;
	localparam int unsigned CNT_W      = 10;
	localparam logic [9:0]  FIFO_FULL  = 10'h200;

	// board decode: ten address bits, five for the board, five for the register
	localparam logic [9:0] BASE_DEFAULT = 10'h220;
	localparam int unsigned BRD_LSB     = 5;

	// register offsets inside the 32-byte window
	localparam logic [4:0] OFF_FIFO   = 5'h00;
	localparam logic [4:0] OFF_STAT   = 5'h02;
	localparam logic [4:0] OFF_IEN    = 5'h04;
	localparam logic [4:0] OFF_ICLR   = 5'h06;
	localparam logic [4:0] OFF_DMA    = 5'h08;
	localparam logic [4:0] OFF_FMT    = 5'h0a;
	localparam logic [4:0] OFF_IRQSEL = 5'h0c;
	localparam logic [4:0] OFF_PEND   = 5'h0e;

	// byte enables for the two transfer sizes
	localparam logic [1:0] SEL_BYTE = 2'h1;
	localparam logic [1:0] SEL_WORD = 2'h3;

	// field positions
	localparam int unsigned STAT_OVF   = 15;
	localparam int unsigned STAT_EMPTY = 14;
	localparam int unsigned CLR_OVF    = 6;
	localparam int unsigned DMA_DUAL   = 0;
	localparam int unsigned DMA_A_LSB  = 1;
	localparam int unsigned DMA_B_LSB  = 4;
	localparam int unsigned DMA_ADC_EN = 8;
	localparam int unsigned DMA_DAC_EN = 9;
	localparam int unsigned FMT_BIP    = 0;

	// interrupt causes
	localparam int unsigned NCAUSE = 6;
	localparam int unsigned C_ADC  = 0;
	localparam int unsigned C_ACQ  = 1;
	localparam int unsigned C_TC   = 2;
	localparam int unsigned C_DACF = 3;
	localparam int unsigned C_DACD = 4;
	localparam int unsigned C_UPD  = 5;

	// reset values and the bipolar sign flip mask
	localparam logic [9:0]  DMA_RST  = 10'h000;
	localparam logic [5:0]  IEN_RST  = 6'h00;
	localparam logic [2:0]  IRQ_RST  = 3'h0;
	localparam logic [15:0] SIGN_FLIP = 16'h8000;

	typedef enum logic [1:0] {PH_IDLE = 2'b01, PH_ACK = 2'b10} phase_type;

	typedef struct packed {
		logic [FIFO_DEPTH-1:0][15:0] mem;
		logic [PTR_W-1:0]            wr_ptr;
		logic [PTR_W-1:0]            rd_ptr;
		logic [CNT_W-1:0]            count;
		logic                        ovf;
		logic [NCAUSE-1:0]           pend;
		logic [NCAUSE-1:0]           ien;
		logic [2:0]                  irq_sel;
		logic [9:0]                  dma_ctl;
		logic                        bipolar;
		phase_type                   ph;
		logic [15:0]                 dat;
		logic [1:0]                  tc_a;
		logic [1:0]                  tc_b;
		logic [1:0]                  upd;
		logic [1:0]                  eisa;
		logic [1:0]                  tc_prev;
		logic                        upd_prev;
		logic                        int_prev;
	} state_type;

endpackage
